/* File: core/hpas_top.sv */
// Device end of the parallel host port: register select, halfword pairing,
// ready signalling and fixed-address transfers to on-chip memory.
// Assumes host pins are asynchronous, memory and APB run on clk_in.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Each data read or write launches one internal memory transfer.
// - Narrow mode: each access is a halfword pair, select low then high.
// - First halfword holds ready inactive while earlier work is outstanding.
// - Second halfword always sees ready active.
// - Wide mode: each access is one 32-bit cycle.
// - Select 00 control, 01 address, 11 data at fixed address.
// - Order 1 means first halfword is low half, 0 means high half.
// - Host address write updates both read and write address copies.
// - Idle fixed read issues the memory read at the strobe falling edge.
// - Data read keeps ready inactive until the word is loaded.
// - Reads fetch whole words; second half has no wait; enables ignored.
// - Idle port reads ready set in both control halves.
// - Wide mode data read returns the full word at once.
// - Both control halves are one storage and read the same.
// - Address is a word address; two low bits read zero.
module hpas_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Host pins
  input wire hpas_pkg::hpas_pins_t host_pins_in,
  output logic host_ready_n_out,
  output logic [31:0] host_data_out,
  output logic host_data_oe_n_out,
  // On-chip memory path
  output var hpas_pkg::hpas_mem_req_t mem_req_out,
  input wire hpas_pkg::hpas_mem_rsp_t mem_rsp_in,
  // APB slave
  input wire hpas_pkg::hpas_apb_req_t apb_req_in,
  output var hpas_pkg::hpas_apb_rsp_t apb_rsp_out
);

  // ----------------------------------------------------------------------
  // Pin synchronisation and strobe edges
  // ----------------------------------------------------------------------
  hpas_pkg::hpas_pins_t pin;
  hpas_pkg::hpas_state_t st_reg;
  hpas_pkg::hpas_state_t st_next;
  logic fall;
  logic rise;
  logic rd_first;
  logic addr_commit;

  hpas_sync #(.W($bits(hpas_pkg::hpas_pins_t))) hpas_sync_inst (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in(host_pins_in),
    .q_out(pin)
  );

  assign fall = st_reg.strobe_d & ~pin.strobe_n;
  assign rise = ~st_reg.strobe_d & pin.strobe_n & st_reg.active;
  assign rd_first = (pin.sel == hpas_pkg::SEL_DATA) & pin.rnw & (pin.wide | ~pin.hw);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic wide, input logic low);
    if (wide) begin
      merge = din;
    end else if (low) begin
      merge = {old[31:16], din[15:0]};
    end else begin
      merge = {din[15:0], old[15:0]};
    end
  endfunction

  // The ready bit reflects whether any transfer is still owed to memory.
  function automatic logic [31:0] ctrl_word(input hpas_pkg::hpas_state_t s);
    logic [15:0] half;
    half = 16'h0000;
    half[hpas_pkg::CTRL_ORDER_BIT] = s.order;
    half[hpas_pkg::CTRL_READY_BIT] = (s.xf == hpas_pkg::XF_IDLE) & ~s.pend_read;
    ctrl_word = {half, half};
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic low;
    logic [31:0] word;
    logic [31:0] wmerged;
    low = 1'b0;
    word = 32'h0000_0000;
    wmerged = 32'h0000_0000;
    addr_commit = 1'b0;
    st_next = st_reg;
    st_next.strobe_d = pin.strobe_n;
    st_next.wide = pin.wide;
    st_next.apb.pready = 1'b0;
    st_next.apb.pslverr = 1'b0;

    // Memory completions. Reads fetch a full word into the data register.
    if (st_reg.xf == hpas_pkg::XF_READ && mem_rsp_in.ack) begin
      st_next.data = mem_rsp_in.rdata;
      st_next.xf = hpas_pkg::XF_IDLE;
      st_next.mem.req = 1'b0;
    end
    if (st_reg.xf == hpas_pkg::XF_WRITE && mem_rsp_in.ack) begin
      st_next.xf = hpas_pkg::XF_IDLE;
      st_next.mem.req = 1'b0;
    end

    // A read that found an earlier write outstanding starts once it ends.
    if (st_next.xf == hpas_pkg::XF_IDLE && st_reg.pend_read) begin
      st_next.pend_read = 1'b0;
      st_next.xf = hpas_pkg::XF_READ;
      st_next.mem = '{req: 1'b1, we: 1'b0, addr: st_reg.raddr[31:2],
                      wdata: 32'h0000_0000, be: hpas_pkg::BE_ALL};
    end

    // Strobe falling edge: latch the access; a first data read issues a fixed-address read.
    if (fall) begin
      st_next.active = 1'b1;
      st_next.sel = pin.sel;
      st_next.rnw = pin.rnw;
      st_next.hw = pin.hw;
      if (rd_first) begin
        st_next.last_rd = 1'b1;
        if (st_next.xf == hpas_pkg::XF_IDLE && !st_next.pend_read) begin
          st_next.xf = hpas_pkg::XF_READ;
          st_next.mem = '{req: 1'b1, we: 1'b0, addr: st_reg.raddr[31:2],
                          wdata: 32'h0000_0000, be: hpas_pkg::BE_ALL};
        end else begin
          st_next.pend_read = 1'b1;
        end
      end
    end

    // APB: one wait-free access phase; answer prepared in the setup cycle.
    if (apb_req_in.psel && !apb_req_in.penable) begin
      st_next.apb.pready = 1'b1;
      case (apb_req_in.paddr)
        hpas_pkg::CTRL_ADDR: st_next.apb.prdata = ctrl_word(st_reg);
        hpas_pkg::WADDR_ADDR: st_next.apb.prdata = st_reg.waddr;
        hpas_pkg::RADDR_ADDR: st_next.apb.prdata = st_reg.raddr;
        default: begin
          st_next.apb.prdata = 32'h0000_0000;
          st_next.apb.pslverr = 1'b1;
        end
      endcase
    end
    // Control fields are host-owned here, so processor writes to them are dropped.
    if (apb_req_in.psel && apb_req_in.penable && st_reg.apb.pready && apb_req_in.pwrite) begin
      case (apb_req_in.paddr)
        hpas_pkg::WADDR_ADDR: st_next.waddr = apb_req_in.pwdata & hpas_pkg::WORD_ADDR_MASK;
        hpas_pkg::RADDR_ADDR: st_next.raddr = apb_req_in.pwdata & hpas_pkg::WORD_ADDR_MASK;
        default: ;
      endcase
    end

    // Strobe rising edge: host writes take effect; host wins over APB.
    if (rise) begin
      st_next.active = 1'b0;
      low = st_reg.order ? ~st_reg.hw : st_reg.hw;
      if (!st_reg.rnw) begin
        case (st_reg.sel)
          hpas_pkg::SEL_CTRL: begin
            st_next.order = pin.data[hpas_pkg::CTRL_ORDER_BIT];
          end
          hpas_pkg::SEL_ADDR: begin
            wmerged = merge(st_reg.waddr, pin.data, st_reg.wide, low)
                      & hpas_pkg::WORD_ADDR_MASK;
            st_next.waddr = wmerged;
            st_next.raddr = wmerged;
            addr_commit = 1'b1;
          end
          hpas_pkg::SEL_DATA: begin
            st_next.last_rd = 1'b0;
            st_next.data = merge(st_reg.data, pin.data, st_reg.wide, low);
            if (st_reg.wide) begin
              st_next.be = hpas_pkg::BE_ALL;
            end else if (low) begin
              st_next.be[1:0] = ~pin.be_n;
            end else begin
              st_next.be[3:2] = ~pin.be_n;
            end
            if ((st_reg.wide || st_reg.hw) && st_next.xf == hpas_pkg::XF_IDLE) begin
              st_next.xf = hpas_pkg::XF_WRITE;
              st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.waddr[31:2],
                              wdata: st_next.data, be: st_next.be};
            end
          end
          default: ;
        endcase
      end
    end

    // Host read data, ready and bus drive follow the settled next state.
    case (st_next.sel)
      hpas_pkg::SEL_CTRL: word = ctrl_word(st_next);
      hpas_pkg::SEL_ADDR: word = st_next.last_rd ? st_next.raddr : st_next.waddr;
      hpas_pkg::SEL_DATA: word = st_next.data;
      default: word = 32'h0000_0000;
    endcase
    low = st_next.order ? ~st_next.hw : st_next.hw;
    if (st_next.wide) begin
      st_next.hd_out = word;
    end else begin
      st_next.hd_out = {16'h0000, low ? word[15:0] : word[31:16]};
    end
    st_next.hd_oe_n = ~(st_next.active & st_next.rnw);
    // Only a first halfword (or a wide cycle) can wait; the second never does.
    st_next.ready_n = st_next.active & (st_next.wide | ~st_next.hw)
                      & ((st_next.xf != hpas_pkg::XF_IDLE) | st_next.pend_read);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg <= hpas_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign host_ready_n_out = st_reg.ready_n;
  assign host_data_out = st_reg.hd_out;
  assign host_data_oe_n_out = st_reg.hd_oe_n;
  assign mem_req_out = st_reg.mem;
  assign apb_rsp_out = st_reg.apb;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_read_issue: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (fall && rd_first && st_reg.xf == hpas_pkg::XF_IDLE && !st_reg.pend_read)
    |=> (mem_req_out.req && !mem_req_out.we && mem_req_out.addr == $past(st_reg.raddr[31:2])))
    else $error("Idle fixed read did not issue a memory read.");

  chk_ready_second: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.active && st_reg.hw && !st_reg.wide) |-> !host_ready_n_out)
    else $error("Second halfword saw ready inactive.");

  chk_ready_busy: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.active && !st_reg.hw && st_reg.xf == hpas_pkg::XF_WRITE) |-> host_ready_n_out)
    else $error("First halfword ready while a write is outstanding.");

  chk_read_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.active && st_reg.rnw && st_reg.sel == hpas_pkg::SEL_DATA
     && (st_reg.wide || !st_reg.hw) && st_reg.xf == hpas_pkg::XF_READ)
    |-> host_ready_n_out throughout (st_reg.xf == hpas_pkg::XF_READ))
    else $error("Ready released before the read word was loaded.");

  chk_read_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.xf == hpas_pkg::XF_READ && mem_rsp_in.ack)
    |=> (st_reg.data == $past(mem_rsp_in.rdata) && !mem_req_out.req))
    else $error("Read word not loaded into the data register.");

  chk_addr_fixed: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.xf == hpas_pkg::XF_READ && mem_rsp_in.ack && !rise && !apb_req_in.psel)
    |=> $stable(st_reg.raddr))
    else $error("Fixed read moved the address.");

  chk_addr_copies: assert property (@(posedge clk_in) disable iff (!nrst_in)
    addr_commit |=> (st_reg.raddr == st_reg.waddr && st_reg.raddr[1:0] == 2'h0))
    else $error("Host address write did not update both copies.");

  chk_addr_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.waddr[1:0] == 2'h0) && (st_reg.raddr[1:0] == 2'h0))
    else $error("Address low bits not zero.");

  chk_ctrl_halves: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (apb_req_in.psel && !apb_req_in.penable && apb_req_in.paddr == hpas_pkg::CTRL_ADDR)
    |=> (apb_rsp_out.prdata[31:16] == apb_rsp_out.prdata[15:0]))
    else $error("Control halves differ.");

  chk_ctrl_ready: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (apb_req_in.psel && !apb_req_in.penable && apb_req_in.paddr == hpas_pkg::CTRL_ADDR
     && st_reg.xf == hpas_pkg::XF_IDLE && !st_reg.pend_read)
    |=> (apb_rsp_out.prdata[19] && apb_rsp_out.prdata[3]))
    else $error("Idle port did not read ready in control.");

  chk_write_launch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (rise && !st_reg.rnw && st_reg.sel == hpas_pkg::SEL_DATA && (st_reg.wide || st_reg.hw)
     && st_reg.xf == hpas_pkg::XF_IDLE && !st_reg.pend_read)
    |=> (mem_req_out.req && mem_req_out.we) [*1] ##1 1'b1)
    else $error("Data write did not launch a memory write.");

  chk_pend_issue: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.pend_read && st_reg.xf == hpas_pkg::XF_WRITE && mem_rsp_in.ack)
    |=> (st_reg.xf == hpas_pkg::XF_READ && mem_req_out.req && !mem_req_out.we))
    else $error("Queued read did not start after the write ended.");

  chk_wide_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (st_reg.active && st_reg.rnw && st_reg.wide && st_reg.sel == hpas_pkg::SEL_DATA
     && !host_ready_n_out) |-> (host_data_out == st_reg.data && !host_data_oe_n_out))
    else $error("Wide data read did not drive the whole word.");

endmodule
`default_nettype wire

/* File: core/hpas_pkg.sv */
// Shared constants, carrier structs and state layout for the host port access sequencer.
// Assumes a single 25 MHz clock domain and an APB master on the same clock.
package hpas_pkg;

  // ----------------------------------------------------------------------
  // Register map seen by the internal processor over APB
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_ADDR = 32'h0188_0000;
  localparam logic [31:0] WADDR_ADDR = 32'h0188_0004;
  localparam logic [31:0] RADDR_ADDR = 32'h0188_0008;

  // ----------------------------------------------------------------------
  // Host access select codes and control word layout
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h3;
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_READY_BIT = 3;
  localparam logic [31:0] WORD_ADDR_MASK = 32'hFFFF_FFFC;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic ORDER_RESET = 1'b0;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {XF_IDLE, XF_READ, XF_WRITE} hpas_xfer_t;

  typedef struct packed {
    logic strobe_n;
    logic [1:0] sel;
    logic rnw;
    logic hw;
    logic [1:0] be_n;
    logic [31:0] data;
    logic wide;
  } hpas_pins_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } hpas_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hpas_apb_rsp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [29:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } hpas_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } hpas_mem_rsp_t;

  typedef struct packed {
    logic strobe_d;
    logic active;
    logic [1:0] sel;
    logic rnw;
    logic hw;
    logic wide;
    logic [3:0] be;
    logic order;
    logic [31:0] waddr;
    logic [31:0] raddr;
    logic last_rd;
    logic [31:0] data;
    hpas_xfer_t xf;
    logic pend_read;
    logic ready_n;
    logic [31:0] hd_out;
    logic hd_oe_n;
    hpas_mem_req_t mem;
    hpas_apb_rsp_t apb;
  } hpas_state_t;

  // The strobe history starts low like the synchroniser output.
  // A high start would see a false strobe fall just after reset.
  localparam hpas_state_t STATE_RESET = '{
    strobe_d: 1'b0, active: 1'b0, sel: SEL_CTRL, rnw: 1'b0, hw: 1'b0, wide: 1'b0,
    be: 4'h0, order: ORDER_RESET, waddr: ADDR_RESET, raddr: ADDR_RESET, last_rd: 1'b0,
    data: DATA_RESET, xf: XF_IDLE, pend_read: 1'b0, ready_n: 1'b0, hd_out: 32'h0000_0000,
    hd_oe_n: 1'b1, mem: '0, apb: '0};

endpackage

/* File: core/hpas_sync.sv */
// Two-stage synchroniser for a bundle of host pins.
// Assumes the bundle is sampled only after a strobe edge has settled it.
`timescale 1ns/1ns
`default_nettype none
module hpas_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Pins
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: bench/hpas_mem_model.sv */
// Behavioural on-chip memory that answers the sequencer's word requests.
// Assumes one outstanding request at a time, on the design's clock.
`timescale 1ns/1ns
`default_nettype none
module hpas_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Answer latency chosen by the bench
  input wire logic [7:0] lat_in,
  // Memory port
  input wire hpas_pkg::hpas_mem_req_t req_in,
  output var hpas_pkg::hpas_mem_rsp_t rsp_out,
  // Observation
  output logic [7:0] n_req_out,
  output logic [29:0] last_addr_out
);
  logic [31:0] mem [16];
  logic busy;
  logic [7:0] cnt;

  // Read data is inverted every cycle outside an ack, so a stale word never looks valid.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      rsp_out <= '0;
      n_req_out <= 8'h00;
      last_addr_out <= '0;
    end else begin
      rsp_out.ack <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
      // A request held into the cycle after an ack is not taken as a new transfer.
      if (req_in.req && !busy && !rsp_out.ack) begin
        busy <= 1'b1;
        cnt <= lat_in;
        n_req_out <= n_req_out + 8'h01;
        last_addr_out <= req_in.addr;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy && req_in.req && !rsp_out.ack) begin
        rsp_out.ack <= 1'b1;
        busy <= 1'b0;
        rsp_out.rdata <= mem[req_in.addr[3:0]];
        for (int i = 0; i < 4; i++) begin
          if (req_in.we && req_in.be[i]) begin
            mem[req_in.addr[3:0]][8*i+:8] <= req_in.wdata[8*i+:8];
          end
        end
      end
      if (busy && !req_in.req) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_host_port_access_sequencer.sv */
// Self-checking bench: host pin cycles, APB register access and a memory model.
// Assumes the sequencer top, its package and the memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_host_port_access_sequencer;
  logic clk_in;
  logic nrst_in;
  hpas_pkg::hpas_pins_t pins;
  hpas_pkg::hpas_apb_req_t apb_req;
  hpas_pkg::hpas_apb_rsp_t apb_rsp;
  hpas_pkg::hpas_mem_req_t mreq;
  hpas_pkg::hpas_mem_rsp_t mrsp;
  logic rdy_n;
  logic hoe_n;
  logic [31:0] hdata;
  logic [7:0] lat;
  logic [7:0] n_req;
  logic [7:0] n0;
  logic [29:0] last_addr;
  logic [31:0] q;
  logic [31:0] rd;
  logic late;
  logic oen;
  logic err;
  int err_count;
  int n_checks;

  hpas_top hpas_top_inst (.clk_in(clk_in), .nrst_in(nrst_in), .host_pins_in(pins),
    .host_ready_n_out(rdy_n), .host_data_out(hdata), .host_data_oe_n_out(hoe_n),
    .mem_req_out(mreq), .mem_rsp_in(mrsp), .apb_req_in(apb_req), .apb_rsp_out(apb_rsp));
  hpas_mem_model hpas_mem_model_inst (.clk_in(clk_in), .nrst_in(nrst_in), .lat_in(lat),
    .req_in(mreq), .rsp_out(mrsp), .n_req_out(n_req), .last_addr_out(last_addr));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task end_sim;
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    @(posedge clk_in);
    while (apb_rsp.pready !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 50) begin
      err_count++;
      end_sim();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // The strobe stays low until ready shows, as the host side must do.
  task automatic host(input logic [1:0] s, input logic rw, input logic h, input logic [31:0] d);
    int n;
    n = 0;
    pins.strobe_n <= 1'b0;
    pins.sel <= s;
    pins.rnw <= rw;
    pins.hw <= h;
    pins.data <= d;
    repeat (6) @(posedge clk_in);
    late = rdy_n;
    while (rdy_n !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 300) begin
      err_count++;
      end_sim();
    end
    q = hdata;
    oen = hoe_n;
    pins.strobe_n <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic hpair(input logic [1:0] s, input logic [15:0] f, input logic [15:0] l);
    host(s, 1'b0, 1'b0, {16'h0000, f});
    host(s, 1'b0, 1'b1, {16'h0000, l});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_idle;
    rd_chk(hpas_pkg::CTRL_ADDR, 32'h0008_0008);
    apb(1'b0, 32'h0188_0010, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, hpas_pkg::RADDR_ADDR, 32'h0000_0013);
    rd_chk(hpas_pkg::RADDR_ADDR, 32'h0000_0010);
  endtask

  task automatic t_init_low_first;
    hpair(hpas_pkg::SEL_CTRL, 16'h0001, 16'h0001);
    hpair(hpas_pkg::SEL_ADDR, 16'h1236, 16'h8000);
    rd_chk(hpas_pkg::CTRL_ADDR, 32'h0009_0009);
    rd_chk(hpas_pkg::WADDR_ADDR, 32'h8000_1234);
    rd_chk(hpas_pkg::RADDR_ADDR, 32'h8000_1234);
    host(hpas_pkg::SEL_CTRL, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(q, 32'h0000_0009)
    host(hpas_pkg::SEL_CTRL, 1'b1, 1'b1, 32'h0000_0000);
    `CHK(q, 32'h0000_0009)
  endtask

  task automatic t_read_fixed;
    lat = 8'h0A;
    hpas_mem_model_inst.mem[13] = 32'h789A_BCDE;
    n0 = n_req;
    for (int i = 0; i < 2; i++) begin
      host(hpas_pkg::SEL_DATA, 1'b1, 1'b0, 32'h0000_0000);
      `CHK(late, 1'b1)
      `CHK(oen, 1'b0)
      `CHK(q, 32'h0000_BCDE)
      `CHK(n_req, n0 + 8'(i + 1))
      host(hpas_pkg::SEL_DATA, 1'b1, 1'b1, 32'h0000_0000);
      `CHK(late, 1'b0)
      `CHK(q, 32'h0000_789A)
      `CHK(n_req, n0 + 8'(i + 1))
      `CHK(last_addr, 30'h2000_048D)
    end
    rd_chk(hpas_pkg::RADDR_ADDR, 32'h8000_1234);
  endtask

  task automatic t_write_high_first;
    hpair(hpas_pkg::SEL_CTRL, 16'h0000, 16'h0000);
    rd_chk(hpas_pkg::CTRL_ADDR, 32'h0008_0008);
    lat = 8'h14;
    pins.be_n <= 2'h0;
    hpair(hpas_pkg::SEL_DATA, 16'h1111, 16'h5566);
    host(hpas_pkg::SEL_ADDR, 1'b0, 1'b0, 32'h0000_8000);
    `CHK(late, 1'b1)
    `CHK(oen, 1'b1)
    host(hpas_pkg::SEL_ADDR, 1'b0, 1'b1, 32'h0000_1234);
    `CHK(late, 1'b0)
    `CHK(hpas_mem_model_inst.mem[13], 32'h1111_5566)
    rd_chk(hpas_pkg::WADDR_ADDR, 32'h8000_1234);
    lat = 8'h03;
    host(hpas_pkg::SEL_DATA, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(q, 32'h0000_1111)
    host(hpas_pkg::SEL_DATA, 1'b1, 1'b1, 32'h0000_0000);
    `CHK(q, 32'h0000_5566)
    hpair(2'h2, 16'hFFFF, 16'hFFFF);
    rd_chk(hpas_pkg::WADDR_ADDR, 32'h8000_1234);
    lat = 8'h14;
    hpair(hpas_pkg::SEL_DATA, 16'h2222, 16'h7788);
    host(hpas_pkg::SEL_DATA, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(late, 1'b1)
    `CHK(q, 32'h0000_2222)
    host(hpas_pkg::SEL_DATA, 1'b1, 1'b1, 32'h0000_0000);
    `CHK(q, 32'h0000_7788)
  endtask

  task automatic t_wide;
    pins.wide <= 1'b1;
    lat = 8'h02;
    hpas_mem_model_inst.mem[14] = 32'hCAFE_F00D;
    repeat (6) @(posedge clk_in);
    host(hpas_pkg::SEL_ADDR, 1'b0, 1'b0, 32'h8000_1238);
    rd_chk(hpas_pkg::RADDR_ADDR, 32'h8000_1238);
    host(hpas_pkg::SEL_DATA, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(q, 32'hCAFE_F00D)
    `CHK(last_addr, 30'h2000_048E)
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    nrst_in = 1'b0;
    lat = 8'h02;
    apb_req = '0;
    pins = '0;
    pins.strobe_n = 1'b1;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_idle();
    t_init_low_first();
    t_read_fixed();
    t_write_high_first();
    t_wide();
    end_sim();
  end
endmodule
`default_nettype wire
